// ---- logic/nand_host_regs.svh ----
// constants of the nand host controller
// Summary of operation
// - host holds byte stable around strobe rise
// - five address cycles, least significant first
// - unused upper address bits driven zero
// - read pairs 00/30, 00/35, 00/31; 34 exits
// - program 80/10, cache 80/15, copyback 85/10
// - erase 60, block address, then D0
// - singles: 90 id, 70 status, FF reset
// - column change 05, column cycles, E0
// - while busy only reset and status
// - program and erase need lock high
// - data out with flags low, strobe high
// - write data with flags low, lock high
// - erase takes three row cycles
`ifndef NAND_HOST_REGS_SVH
`define NAND_HOST_REGS_SVH
`define CMD_READ_SETUP    8'h00
`define CMD_READ_GO       8'h30
`define CMD_READ_COPYBACK 8'h35
`define CMD_CACHE_READ    8'h31
`define CMD_CACHE_EXIT    8'h34
`define CMD_PROG_SETUP    8'h80
`define CMD_PROG_GO       8'h10
`define CMD_CACHE_PROG    8'h15
`define CMD_COPYBACK_PROG 8'h85
`define CMD_ERASE_SETUP   8'h60
`define CMD_ERASE_GO      8'hd0
`define CMD_READ_ID       8'h90
`define CMD_STATUS        8'h70
`define CMD_RESET         8'hff
`define CMD_COL_OUT       8'h05
`define CMD_COL_OUT_GO    8'he0
`define STATUS_READY_BIT  6
`define STATUS_FAIL_BIT   0
`define ADDR_CYCLES_FULL  3'h5
`define ADDR_CYCLES_COL   3'h2
`define ADDR_CYCLES_ROW   3'h3
`define SYS_CLK_NS        20
`define STROBE_NS         40
`define STROBE_CYCLES     ((`STROBE_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`endif

// ---- logic/nand_host_pkg.sv ----
// types of the nand host controller
package nand_host_pkg;
	typedef enum logic [2:0]
	{
		OP_CMD  = 3'h0,
		OP_ADDR = 3'h1,
		OP_WDATA = 3'h2,
		OP_RDATA = 3'h3,
		OP_WAIT = 3'h4
	} op_kind_t;

	typedef struct packed
	{
		op_kind_t    kind;
		logic [7:0]  value;
		logic        modify;
	} request_t;

	typedef struct packed
	{
		logic       cmdLatch;
		logic       addrLatch;
		logic       selectN;
		logic       inStrobeN;
		logic       outStrobeN;
		logic       lockN;
	} pins_t;

	typedef enum logic [5:0]
	{
		ST_IDLE  = 6'b000001,
		ST_SETUP = 6'b000010,
		ST_LOW   = 6'b000100,
		ST_HIGH  = 6'b001000,
		ST_WAIT  = 6'b010000,
		ST_DONE  = 6'b100000
	} state_t;
endpackage

// ---- logic/byte_fifo.sv ----
// small valid/ready fifo for read data
`timescale 1ns/1ns
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
)(
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    wrPtr;
	logic [AW-1:0]    rdPtr;
	logic [AW:0]      count;
	wire              doWrite = inValid && inReady;
	wire              doRead  = outValid && outReady;

	assign inReady  = (count != DEPTH[AW:0]);
	assign outValid = (count != '0);
	assign outData  = store[rdPtr];

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end
		else
		begin
			if (doWrite)
				wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
			if (doRead)
				rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
			count <= count + (AW+1)'(doWrite) - (AW+1)'(doRead);
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (doWrite)
			store[wrPtr] <= inData;
	end
endmodule

// ---- logic/nand_host.sv ----
// host controller driving the nand pins one bus cycle at a time
`timescale 1ns/1ns
`include "nand_host_regs.svh"
module nand_host (
	input  wire logic                    sys_clk,
	input  wire logic                    rstn,
	input  wire nand_host_pkg::request_t reqData,
	input  wire logic                    reqValid,
	output logic                         reqReady,
	output logic                         writeProtect,
	input  wire logic                    allowModify,
	output logic                         rdValid,
	input  wire logic                    rdReady,
	output logic [7:0]                   rdData,
	output logic                         refused,
	output logic                         deviceBusy,
	output nand_host_pkg::pins_t         pins,
	output logic [7:0]                   busOut,
	output logic                         busOe_n,
	input  wire logic [7:0]              busIn,
	input  wire logic                    readyBusyIn
);
	import nand_host_pkg::*;

	state_t     state;
	state_t     next_state;
	request_t   cur;
	logic [1:0] tick;
	logic [1:0] rbSync;
	logic [7:0] busS1;
	logic [7:0] busS2;
	logic       inSetup;
	logic       fifoReady;
	logic       capVal;
	logic [2:0] addrLane;
	request_t   next_cur;

	wire logic rbReady = rbSync[1];
	wire logic cmdBusyOk = (reqData.value == `CMD_RESET) || (reqData.value == `CMD_STATUS);
	wire logic blockMod = reqData.modify && !allowModify;
	// busy blocks other commands
	// reads and waits still pass so the status byte can be polled
	wire logic busyBlock = !rbReady && ((reqData.kind == OP_CMD && !cmdBusyOk) || reqData.kind == OP_ADDR
	                                    || reqData.kind == OP_WDATA);
	wire logic accept = reqValid && (state == ST_IDLE) && !busyBlock && !blockMod;
	wire logic tickDone = (tick == 2'(`STROBE_CYCLES - 1));
	wire logic isRead = (cur.kind == OP_RDATA);
	wire logic isWrite = (cur.kind != OP_RDATA) && (cur.kind != OP_WAIT);

	function automatic logic [7:0] laneMask(input logic [2:0] lane);
		case (lane)
			3'h1:
				laneMask = 8'h0f;
			3'h4:
				laneMask = 8'h03;
			default:
				laneMask = 8'hff;
		endcase
	endfunction

	wire logic       eraseSetup = (reqData.value == `CMD_ERASE_SETUP);
	wire logic [2:0] firstLane  = eraseSetup ? `ADDR_CYCLES_COL : 3'h0;
	wire logic       takeCmd    = accept && (reqData.kind == OP_CMD);
	wire logic       takeAddr   = accept && (reqData.kind == OP_ADDR);
	wire logic [7:0] laneValue  = reqData.value & laneMask(addrLane);

	assign next_cur = '{kind: reqData.kind, value: (reqData.kind == OP_ADDR) ? laneValue : reqData.value,
	                   modify: reqData.modify};

	assign reqReady = (state == ST_IDLE) && !busyBlock && !blockMod;
	assign refused = reqValid && (state == ST_IDLE) && (busyBlock || blockMod);
	assign deviceBusy = !rbReady;

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			// line idles released high, so no false busy after reset
			rbSync <= 2'h3;
			busS1 <= 8'h00;
			busS2 <= 8'h00;
		end
		else
		begin
			rbSync <= {rbSync[0], readyBusyIn};
			busS1 <= busIn;
			busS2 <= busS1;
		end
	end

	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:
				if (accept)
					next_state = (reqData.kind == OP_WAIT) ? ST_WAIT : ST_SETUP;
			ST_SETUP:
				if (tickDone)
					next_state = ST_LOW;
			ST_LOW:
				if (tickDone)
					next_state = ST_HIGH;
			ST_HIGH:
				if (tickDone && (!isRead || fifoReady))
					next_state = ST_DONE;
			// wait covers array time; select may drop meanwhile
			ST_WAIT:
				if (rbReady && tickDone)
					next_state = ST_DONE;
			ST_DONE:
				next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state <= ST_IDLE;
			cur <= '0;
			tick <= 2'h0;
		end
		else
		begin
			state <= next_state;
			tick <= (next_state != state) ? 2'h0 : (tickDone ? tick : tick + 2'h1);
			if (accept)
				cur <= next_cur;
		end
	end

	// lane saturates; a runaway burst cannot wrap onto lane zero
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			addrLane <= 3'h0;
		else if (takeCmd)
			addrLane <= firstLane;
		else if (takeAddr && (addrLane != 3'h7))
			addrLane <= addrLane + 3'h1;
	end

	wire logic active = (state == ST_SETUP) || (state == ST_LOW) || (state == ST_HIGH);
	assign inSetup = active;

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pins <= '{cmdLatch: 1'b0, addrLatch: 1'b0, selectN: 1'b1,
			          inStrobeN: 1'b1, outStrobeN: 1'b1, lockN: 1'b0};
			busOut <= 8'h00;
			busOe_n <= 1'b1;
			writeProtect <= 1'b1;
		end
		else
		begin
			pins.cmdLatch <= inSetup && (cur.kind == OP_CMD);
			pins.addrLatch <= inSetup && (cur.kind == OP_ADDR);
			pins.selectN <= !inSetup;
			pins.inStrobeN <= !(isWrite && state == ST_LOW);
			pins.outStrobeN <= !(isRead && state == ST_LOW);
			pins.lockN <= allowModify;
			writeProtect <= !allowModify;
			busOut <= isWrite ? cur.value : 8'h00;
			busOe_n <= !(isWrite && inSetup);
		end
	end

	// take byte once
	// the strobe-low sample leaves busS2 two edges later, in the high phase
	wire logic capture = isRead && (state == ST_HIGH) && tickDone && !capVal;

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			rdData <= 8'h00;
		else if (capture)
			rdData <= busS2;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			capVal <= 1'b0;
		else if (capture)
			capVal <= 1'b1;
		else if (fifoReady)
			capVal <= 1'b0;
	end

	byte_fifo #(.WIDTH(8), .DEPTH(8)) readBuffer (
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.inValid  (capVal),
		.inReady  (fifoReady),
		.inData   (rdData),
		.outValid (rdValid),
		.outReady (rdReady),
		.outData  ()
	);
endmodule

// ---- verif/nand_dev_model.sv ----
// behavioural nand device answering the host pins
`timescale 1ns/1ns
module nand_dev_model (
	input  wire nand_host_pkg::pins_t pins,
	input  wire logic [7:0]           busOut,
	input  wire logic                 busOe_n,
	output wire logic [7:0]           busIn,
	output wire                       readyBusyIn
);
	import nand_host_pkg::*;
	logic [39:0] addr = '0;
	logic [7:0]  outByte = '0;
	logic [11:0] col = '0;
	int          cyc = 0;
	int          dur = 0;
	logic        busy = 0;
	logic        armed = 0;
	logic        statMode = 0;
	event        go;
	assign busIn = !pins.selectN && !pins.outStrobeN ? outByte : !busOe_n ? busOut : ~outByte;
	assign readyBusyIn = busy ? 1'b0 : 1'bz;
	// busy runs out whatever the select
	always @go
	begin
		busy = 1;
		#(dur) busy = 0;
	end
	always @(posedge pins.inStrobeN)
		if (!pins.selectN && pins.addrLatch)
		begin
			addr[cyc*8 +: 8] = busIn;
			cyc++;
		end
		// only reset and status while busy
		else if (!pins.selectN && pins.cmdLatch && (!busy || busIn inside {8'hff, 8'h70}))
		begin
			cyc = 0;
			statMode = busIn == 8'h70;
			dur = armed && pins.lockN && busIn inside {8'h10, 8'h15, 8'hd0} ? 4000 : 0;
			if (busIn inside {8'h30, 8'h35, 8'h31})
			begin
				dur = 400;
				col = addr[11:0];
			end
			if (dur > 0)
				->go;
			armed = busIn inside {8'h80, 8'h85, 8'h60};
		end
	always @(negedge pins.outStrobeN)
		if (!pins.selectN)
		begin
			outByte = statMode ? {1'b0, !busy, 6'h00} : col[7:0] ^ 8'h5a;
			col++;
		end
endmodule

// ---- verif/nand_host_chk.sv ----
// pin and request assertions for the nand host
`timescale 1ns/1ns
module nand_host_chk (
	input wire logic                    sys_clk,
	input wire logic                    rstn,
	input wire nand_host_pkg::request_t reqData,
	input wire logic                    reqValid,
	input wire logic                    allowModify,
	input wire logic                    writeProtect,
	input wire logic                    refused,
	input wire logic                    deviceBusy,
	input wire logic                    readyBusyIn,
	input wire nand_host_pkg::pins_t    pins,
	input wire logic [7:0]              busOut,
	input wire logic                    busOe_n
);
	import nand_host_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	a_protect_follows: assert property (!allowModify |=> writeProtect)
		else $error("protect not raised");
	a_busy_refuse: assert property (reqValid && deviceBusy && reqData.kind == OP_CMD
		&& !(reqData.value inside {8'hff, 8'h70}) |-> refused) else $error("busy command taken");
	a_lock_refuse: assert property (reqValid && reqData.modify && !allowModify && writeProtect |-> refused)
		else $error("locked modify taken");
	a_flags_apart: assert property (!(pins.cmdLatch && pins.addrLatch))
		else $error("both latch flags");
	a_strobes_apart: assert property (!pins.inStrobeN |-> pins.outStrobeN && !pins.selectN)
		else $error("bad write strobe");
	a_hold_bus: assert property (!pins.inStrobeN |=> $stable(busOut) && !busOe_n)
		else $error("bus moved at strobe");
	a_read_float: assert property (!pins.outStrobeN |-> busOe_n && !pins.selectN)
		else $error("bus driven in read");
	a_busy_sync: assert property (!readyBusyIn [*4] |-> deviceBusy)
		else $error("busy not seen");
	c_refused: cover property (refused && deviceBusy);
	c_read: cover property ($fell(pins.outStrobeN));
	c_addr: cover property (pins.addrLatch && !pins.inStrobeN);
endmodule
bind nand_host nand_host_chk nand_host_chk_i (.sys_clk, .rstn, .reqData, .reqValid, .allowModify, .writeProtect,
	.refused, .deviceBusy, .readyBusyIn, .pins, .busOut, .busOe_n);

// ---- verif/nand_host_test.sv ----
// self-checking bench for the nand host
`timescale 1ns/1ns
module nand_host_test;
	import nand_host_pkg::*;
	logic       sys_clk = 0;
	logic       rstn = 0;
	request_t   reqData = '0;
	logic       reqValid = 0;
	logic       allowModify = 1;
	logic       rdReady = 1;
	logic       lastRef = 0;
	logic       reqReady, writeProtect, rdValid, refused, deviceBusy, busOe_n;
	logic [7:0] rdData, busOut;
	wire  [7:0] busIn;
	pins_t      pins;
	wire        readyBusyIn;
	int         n_errors = 0;
	int         compares = 0;
	pullup (readyBusyIn);
	nand_host nand_host_i (.sys_clk, .rstn, .reqData, .reqValid, .reqReady, .writeProtect, .allowModify, .rdValid,
		.rdReady, .rdData, .refused, .deviceBusy, .pins, .busOut, .busOe_n, .busIn, .readyBusyIn);
	nand_dev_model nand_dev_model_i (.pins, .busOut, .busOe_n, .busIn, .readyBusyIn);
	initial
		forever #10 sys_clk = ~sys_clk;
	task check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task results;
		if (n_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// offer one request, then wait until the machine is free again
	task send(input op_kind_t k, input logic [7:0] v, input logic m);
		int n;
		n = 0;
		@(posedge sys_clk);
		#1 reqData = '{k, v, m};
		reqValid = 1;
		#1;
		while (!(reqReady || refused) && n < 20000)
		begin
			@(posedge sys_clk);
			#2 n++;
		end
		lastRef = refused;
		@(posedge sys_clk);
		#1 reqValid = 0;
		// neutral pattern: ready then reflects only the machine
		reqData = '{OP_WAIT, 8'h00, 1'b0};
		while (!reqReady && n < 20000)
		begin
			@(posedge sys_clk);
			#1 n++;
		end
	endtask
	task t_read;
		send(OP_CMD, 8'h00, 0);
		for (int i = 0; i < 5; i++)
			send(OP_ADDR, i == 0 ? 8'h03 : i == 1 ? 8'hf1 : i == 2 ? 8'h07 : 8'h00, 0);
		send(OP_CMD, 8'h30, 0);
		send(OP_WAIT, 8'h00, 0);
		check(nand_dev_model_i.addr[23:16], 8'h07);
		check(nand_dev_model_i.addr[15:8], 8'h01);
		rdReady = 0;
		for (int i = 3; i < 6; i++)
		begin
			send(OP_RDATA, 8'h00, 0);
			check(rdData, 8'(i) ^ 8'h5a);
		end
		check(8'(rdValid), 8'h01);
		rdReady = 1;
		repeat (4) @(posedge sys_clk);
		#1 check(8'(rdValid), 8'h00);
	endtask
	task t_erase;
		send(OP_CMD, 8'h60, 1);
		send(OP_ADDR, 8'h11, 1);
		send(OP_ADDR, 8'h22, 1);
		send(OP_ADDR, 8'hff, 1);
		send(OP_CMD, 8'hd0, 1);
		check(8'(deviceBusy), 8'h01);
		check(nand_dev_model_i.addr[23:16], 8'h03);
		send(OP_WAIT, 8'h00, 0);
		check(8'(deviceBusy), 8'h00);
	endtask
	task t_busy;
		send(OP_CMD, 8'h80, 1);
		for (int i = 0; i < 5; i++)
			send(OP_ADDR, 8'h00, 1);
		send(OP_WDATA, 8'h3c, 1);
		send(OP_CMD, 8'h10, 1);
		repeat (4) @(posedge sys_clk);
		send(OP_CMD, 8'h90, 0);
		check(8'(lastRef), 8'h01);
		send(OP_CMD, 8'h70, 0);
		check(8'(lastRef), 8'h00);
		send(OP_RDATA, 8'h00, 0);
		check(rdData, 8'h00);
		send(OP_WAIT, 8'h00, 0);
		check(8'(deviceBusy), 8'h00);
		send(OP_RDATA, 8'h00, 0);
		check(rdData, 8'h40);
	endtask
	task t_lock;
		@(posedge sys_clk);
		#1 allowModify = 0;
		send(OP_CMD, 8'h60, 1);
		check(8'(lastRef), 8'h01);
		check(8'(writeProtect), 8'h01);
		send(OP_CMD, 8'h70, 0);
		check(8'(lastRef), 8'h00);
		allowModify = 1;
	endtask
	initial
	begin
		repeat (10) @(posedge sys_clk);
		#1 rstn = 1;
		t_read;
		t_busy;
		t_erase;
		t_lock;
		results;
	end
	// a few dozen requests and three busy spans need well under this
	initial
	begin
		#200000;
		n_errors++;
		results;
	end
endmodule
